// File: inc/scad_defs.svh
// Constants for the stream channel adapter: offsets, fields, resets, defaults
`ifndef SCAD_DEFS_SVH
`define SCAD_DEFS_SVH

`define SCAD_ADDR_W 8
`define SCAD_DATA_W 32

`define SCAD_OFF_STATUS 8'h00
`define SCAD_OFF_CLEAR 8'h04
`define SCAD_OFF_ENABLE 8'h08
`define SCAD_OFF_SINK_MAX 8'h0C
`define SCAD_OFF_DROPS 8'h10
`define SCAD_OFF_INFO 8'h14

`define SCAD_EVT_W 2
`define SCAD_BIT_NONZERO 0
`define SCAD_BIT_RANGE 1

`define SCAD_RST_ENABLE 2'h0
`define SCAD_RST_DROPS 16'h0000

`define SCAD_CHAN_W_MAX 8
`define SCAD_CHAN_MAX_LIMIT 255
`define SCAD_ERR_W_MAX 31

`define SCAD_DEF_IN_CHAN_W 4
`define SCAD_DEF_OUT_CHAN_W 2
`define SCAD_DEF_IN_MAX_CHAN 15
`define SCAD_DEF_OUT_MAX_CHAN 2
`define SCAD_DEF_BITS_PER_SYM 8
`define SCAD_DEF_SYM_PER_BEAT 4
`define SCAD_DEF_ERR_W 1
`define SCAD_DEF_READY_LAT 0

`endif

// File: inc/scad_pkg.sv
// Types shared by the stream channel adapter
package scad_pkg;

    typedef logic [7:0] scad_chan_t;
    typedef logic [15:0] scad_count_t;
    typedef logic [1:0] scad_evt_t;

    typedef enum logic [2:0]
    {
        SCAD_REG_STATUS = 3'b000,
        SCAD_REG_CLEAR = 3'b001,
        SCAD_REG_ENABLE = 3'b010,
        SCAD_REG_SINK_MAX = 3'b011,
        SCAD_REG_DROPS = 3'b100,
        SCAD_REG_INFO = 3'b101,
        SCAD_REG_NONE = 3'b111
    } scad_reg_e;

endpackage

// File: src/scad_adapter.sv
// Stream channel adapter between a source and a sink with differing channel support
//
// Overview of operation
// - Channel field on each side is at most eight bits, n bits reach 2^n channels.
// - A channel width of zero means that side carries no channel number.
// - Each side's maximum channel number lies between 0 and 255; max_chan_a does not check the sink's lower bound.
// - With backpressure the sink's ready stalls the source; without it nothing stalls.
// - Source drives valid only ready-latency cycles after the sink asserts ready.
// - Start, end of packet and empty count are forwarded unchanged.
// - On the end-of-packet beat, empty counts symbol positions holding no data.
// - Empty is omitted when a beat carries exactly one symbol.
// - Error field is 0 to 31 bits; zero carries no error values.
// - Error bits join directly only when source and sink meanings match.
// - Channelled source into channelless sink flags any nonzero channel beat.
// - Channelless source drives every sink channel bit to zero.
// - Channel passes unchanged; extra sink bits zero, extra source bits dropped.
// - Channel above sink maximum flags an error and suppresses valid to the sink.
//
// The plain strobed port and the address map were left to the implementer.
`timescale 1ns/1ps
`include "scad_defs.svh"

module scad_adapter
    import scad_pkg::*;
#(
    parameter int IN_CHAN_W = `SCAD_DEF_IN_CHAN_W,
    parameter int OUT_CHAN_W = `SCAD_DEF_OUT_CHAN_W,
    parameter int IN_MAX_CHAN = `SCAD_DEF_IN_MAX_CHAN,
    parameter int OUT_MAX_CHAN = `SCAD_DEF_OUT_MAX_CHAN,
    parameter int BITS_PER_SYM = `SCAD_DEF_BITS_PER_SYM,
    parameter int SYM_PER_BEAT = `SCAD_DEF_SYM_PER_BEAT,
    parameter int ERR_W = `SCAD_DEF_ERR_W,
    parameter int READY_LAT = `SCAD_DEF_READY_LAT,
    parameter bit USE_READY = 1'b1,
    parameter bit USE_PACKETS = 1'b1,
    parameter bit USE_EMPTY = 1'b1,
    localparam int DATA_W = BITS_PER_SYM * SYM_PER_BEAT,
    localparam int EMPTY_W = (SYM_PER_BEAT > 1) ? $clog2(SYM_PER_BEAT) : 1,
    localparam int IN_CW = (IN_CHAN_W > 0) ? IN_CHAN_W : 1,
    localparam int OUT_CW = (OUT_CHAN_W > 0) ? OUT_CHAN_W : 1,
    localparam int ERR_PW = (ERR_W > 0) ? ERR_W : 1
)
(
    input wire logic ref_clk, // System clock, 50 MHz
    input wire logic reset_n, // Synchronous reset, active low
    input wire logic in_valid, // Source beat valid
    output logic in_ready, // Ready back to source
    input wire logic [DATA_W-1:0] in_data, // Source data
    input wire logic [IN_CW-1:0] in_channel, // Source channel
    input wire logic in_sop, // Source start of packet
    input wire logic in_eop, // Source end of packet
    input wire logic [EMPTY_W-1:0] in_empty, // Source empty count
    input wire logic [ERR_PW-1:0] in_error, // Source error bits
    output logic out_valid, // Beat valid to sink
    input wire logic out_ready, // Sink ready
    output logic [DATA_W-1:0] out_data, // Sink data
    output logic [OUT_CW-1:0] out_channel, // Sink channel
    output logic out_sop, // Sink start of packet
    output logic out_eop, // Sink end of packet
    output logic [EMPTY_W-1:0] out_empty, // Sink empty count
    output logic [ERR_PW-1:0] out_error, // Sink error bits
    output logic chan_error, // Channel error on this beat
    input wire logic [`SCAD_ADDR_W-1:0] reg_addr, // Register address
    input wire logic [`SCAD_DATA_W-1:0] reg_wdata, // Register write data
    input wire logic reg_wr, // Register write strobe
    input wire logic reg_rd, // Register read strobe
    output logic [`SCAD_DATA_W-1:0] reg_rdata, // Read data, cycle after strobe
    output logic irq // Interrupt, level
);

    localparam bit SRC_CH = (IN_CHAN_W > 0);
    localparam bit SNK_CH = (OUT_CHAN_W > 0);
    localparam bit HAS_EMPTY = USE_PACKETS && USE_EMPTY && (SYM_PER_BEAT > 1);

    scad_evt_t status;
    scad_evt_t enable;
    scad_evt_t next_status;
    scad_evt_t event_now;
    scad_chan_t sink_max;
    scad_chan_t src_chan;
    scad_count_t drops;
    scad_reg_e sel;
    logic nonzero_hit;
    logic range_hit;
    logic [READY_LAT:0] ready_hist;

    // Source channel widened to eight bits for compare
    always_comb
    begin
        src_chan = '0;
        if (SRC_CH)
        begin
            src_chan[IN_CW-1:0] = in_channel;
        end
    end

    assign nonzero_hit = in_valid && SRC_CH && !SNK_CH && (src_chan != 8'h00);

    assign range_hit = in_valid && SRC_CH && SNK_CH && (src_chan > sink_max);

    assign event_now[`SCAD_BIT_NONZERO] = nonzero_hit;
    assign event_now[`SCAD_BIT_RANGE] = range_hit;
    assign chan_error = nonzero_hit || range_hit;

    assign in_ready = USE_READY ? out_ready : 1'b1;

    assign out_valid = in_valid && !range_hit;

    // combinational data path
    // Data left unregistered so ready latency is not disturbed
    assign out_data = in_data;

    assign out_sop = USE_PACKETS ? in_sop : 1'b0;
    assign out_eop = USE_PACKETS ? in_eop : 1'b0;

    // empty tied off for one-symbol beats
    assign out_empty = HAS_EMPTY ? in_empty : '0;

    assign out_error = (ERR_W > 0) ? in_error : '0;

    // zero when source has no channel
    // absent side leaves a tied-off bit
    generate
        for (genvar i = 0; i < OUT_CW; i++)
        begin : g_chan
            if (SNK_CH && SRC_CH && (i < IN_CHAN_W))
            begin : g_pass
                assign out_channel[i] = in_channel[i];
            end
            else
            begin : g_zero
                assign out_channel[i] = 1'b0;
            end
        end
    endgenerate

    // Address decode
    always_comb
    begin
        case (reg_addr)
            `SCAD_OFF_STATUS: sel = SCAD_REG_STATUS;
            `SCAD_OFF_CLEAR: sel = SCAD_REG_CLEAR;
            `SCAD_OFF_ENABLE: sel = SCAD_REG_ENABLE;
            `SCAD_OFF_SINK_MAX: sel = SCAD_REG_SINK_MAX;
            `SCAD_OFF_DROPS: sel = SCAD_REG_DROPS;
            `SCAD_OFF_INFO: sel = SCAD_REG_INFO;
            default: sel = SCAD_REG_NONE;
        endcase
    end

    // Sticky status: a set in the clear cycle wins
    always_comb
    begin
        next_status = status;
        if (reg_wr && (sel == SCAD_REG_CLEAR))
        begin
            next_status = status & ~reg_wdata[`SCAD_EVT_W-1:0];
        end
        next_status = next_status | event_now;
    end

    always_ff @(posedge ref_clk)
    begin
        if (!reset_n)
        begin
            status <= '0;
        end
        else
        begin
            status <= next_status;
        end
    end

    always_ff @(posedge ref_clk)
    begin
        if (!reset_n)
        begin
            enable <= `SCAD_RST_ENABLE;
        end
        else if (reg_wr && (sel == SCAD_REG_ENABLE))
        begin
            enable <= reg_wdata[`SCAD_EVT_W-1:0];
        end
    end

    // sink maximum, software may raise or lower it
    always_ff @(posedge ref_clk)
    begin
        if (!reset_n)
        begin
            sink_max <= 8'(OUT_MAX_CHAN);
        end
        else if (reg_wr && (sel == SCAD_REG_SINK_MAX))
        begin
            sink_max <= reg_wdata[7:0];
        end
    end

    // Dropped beat count, saturates instead of wrapping
    always_ff @(posedge ref_clk)
    begin
        if (!reset_n)
        begin
            drops <= `SCAD_RST_DROPS;
        end
        else if (range_hit && (drops != 16'hFFFF))
        begin
            drops <= drops + 16'h0001;
        end
    end

    always_ff @(posedge ref_clk)
    begin
        if (!reset_n)
        begin
            irq <= 1'b0;
        end
        else
        begin
            irq <= |(next_status & enable);
        end
    end

    // Read data valid only in the cycle after the strobe
    always_ff @(posedge ref_clk)
    begin
        if (!reset_n)
        begin
            reg_rdata <= '0;
        end
        else if (reg_rd)
        begin
            case (sel)
                SCAD_REG_STATUS: reg_rdata <= {30'h0, status};
                SCAD_REG_ENABLE: reg_rdata <= {30'h0, enable};
                SCAD_REG_SINK_MAX: reg_rdata <= {24'h0, sink_max};
                SCAD_REG_DROPS: reg_rdata <= {16'h0, drops};
                SCAD_REG_INFO: reg_rdata <= {8'h0, 8'(IN_MAX_CHAN), 4'(IN_CHAN_W), 4'(OUT_CHAN_W), 8'(ERR_W)};
                default: reg_rdata <= '0;
            endcase
        end
        else
        begin
            reg_rdata <= '0;
        end
    end

    // Ready history for the latency check, bit k is ready k+1 cycles back
    always_ff @(posedge ref_clk)
    begin
        if (!reset_n)
        begin
            ready_hist <= '0;
        end
        else
        begin
            ready_hist[0] <= out_ready;
            for (int k = 1; k <= READY_LAT; k++)
            begin
                ready_hist[k] <= ready_hist[k-1];
            end
        end
    end

    chan_width_a: assert property (@(posedge ref_clk)
        (IN_CHAN_W <= 8) && (OUT_CHAN_W <= 8))
        else $error("Channel width above eight bits");

    max_chan_a: assert property (@(posedge ref_clk)
        (IN_MAX_CHAN <= 255) && (OUT_MAX_CHAN <= 255) && (IN_MAX_CHAN >= 0))
        else $error("Max channel outside 0 to 255");

    err_width_a: assert property (@(posedge ref_clk)
        (ERR_W >= 0) && (ERR_W <= 31))
        else $error("Error width outside 0 to 31");

    range_drop_a: assert property (@(posedge ref_clk) disable iff (!reset_n)
        (in_valid && SRC_CH && SNK_CH && (src_chan > sink_max)) |-> (!out_valid && chan_error))
        else $error("Out-of-range beat passed to sink");

    range_pass_a: assert property (@(posedge ref_clk) disable iff (!reset_n)
        (in_valid && !chan_error) |-> out_valid)
        else $error("Valid beat lost");

    nonzero_flag_a: assert property (@(posedge ref_clk) disable iff (!reset_n)
        (in_valid && SRC_CH && !SNK_CH && (in_channel != '0)) |-> chan_error ##1 status[`SCAD_BIT_NONZERO])
        else $error("Nonzero channel not flagged");

    chan_zero_a: assert property (@(posedge ref_clk) disable iff (!reset_n)
        !SRC_CH |-> (out_channel == '0))
        else $error("Sink channel not zero");

    chan_pass_a: assert property (@(posedge ref_clk) disable iff (!reset_n)
        (SRC_CH && SNK_CH) |-> (out_channel == OUT_CW'(src_chan)))
        else $error("Channel not passed unchanged");

    ready_path_a: assert property (@(posedge ref_clk) disable iff (!reset_n)
        USE_READY |-> (in_ready == out_ready))
        else $error("Ready not routed back");

    // valid follows ready by the latency
    ready_lat_a: assert property (@(posedge ref_clk) disable iff (!reset_n)
        (USE_READY && out_valid && $past(reset_n)) |-> ready_hist[(READY_LAT > 0) ? READY_LAT - 1 : 0] || (READY_LAT == 0))
        else $error("Valid outside ready latency");

    frame_pass_a: assert property (@(posedge ref_clk) disable iff (!reset_n)
        USE_PACKETS |-> (out_sop == in_sop) && (out_eop == in_eop) && (out_data == in_data))
        else $error("Framing or data altered");

    // Range status bit sticks until cleared
    status_hold_a: assert property (@(posedge ref_clk) disable iff (!reset_n)
        (status[`SCAD_BIT_RANGE] && !(reg_wr && (sel == SCAD_REG_CLEAR))) |=> status[`SCAD_BIT_RANGE])
        else $error("Status bit dropped without clear");

    drop_beat_c: cover property (@(posedge ref_clk) disable iff (!reset_n) range_hit);
    pass_beat_c: cover property (@(posedge ref_clk) disable iff (!reset_n) out_valid && out_ready && out_eop);
    irq_rise_c: cover property (@(posedge ref_clk) disable iff (!reset_n) !irq ##1 irq);
    clear_race_c: cover property (@(posedge ref_clk) disable iff (!reset_n)
        range_hit && reg_wr && (sel == SCAD_REG_CLEAR));

endmodule // scad_adapter

// File: tb/scad_sink_model.sv
// Sink model for the channel adapter: ready with optional stalls, beat counter
`timescale 1ns/1ps

module scad_sink_model
(
    input wire logic ref_clk, // System clock
    input wire logic reset_n, // Synchronous reset, active low
    input wire logic slow, // Stall at random when high
    input wire logic out_valid, // Beat valid from adapter
    output logic out_ready, // Ready to adapter
    output logic [15:0] beats // Beats taken
);
    always_ff @(posedge ref_clk)
    begin
        if (!reset_n)
            out_ready <= 1'b0;
        else
            out_ready <= !slow || ($urandom % 3 != 0);
    end

    always_ff @(posedge ref_clk)
    begin
        if (!reset_n)
            beats <= 16'h0000;
        else if (out_valid && out_ready)
            beats <= beats + 16'h0001;
    end
endmodule // scad_sink_model

// File: tb/scad_adapter_tb.sv
// Self-checking bench for the stream channel adapter
`timescale 1ns/1ps
`include "scad_defs.svh"

module scad_adapter_tb
    import scad_pkg::*;
;
    logic ref_clk = 1'b0, reset_n = 1'b0, in_valid = 1'b0, in_sop = 1'b0, in_eop = 1'b0;
    logic reg_wr = 1'b0, reg_rd = 1'b0, slow = 1'b0;
    logic [31:0] in_data = 32'h0, reg_wdata = 32'h0;
    logic [3:0] in_channel = 4'h0;
    logic [1:0] in_empty = 2'h0;
    logic [0:0] in_error = 1'h0;
    logic [7:0] reg_addr = 8'h00;
    logic in_ready, out_valid, out_ready, out_sop, out_eop, chan_error, irq, b_valid, b_error, b_chan;
    logic c_valid, c_error;
    logic [31:0] out_data, reg_rdata;
    logic [1:0] out_channel, out_empty, c_chan;
    logic [0:0] out_error;
    logic [15:0] beats;
    int fail_count = 0, checks = 0, exp_beats = 0, cur_max = 2;
    typedef struct { logic v; logic e; logic be; logic [1:0] ch; logic [4:0] f; logic [31:0] d; } scad_exp_s;
    scad_exp_s q[$];
    scad_exp_s m;

    scad_adapter scad_adapter_i (.ref_clk, .reset_n, .in_valid, .in_ready, .in_data, .in_channel, .in_sop, .in_eop,
        .in_empty, .in_error, .out_valid, .out_ready, .out_data, .out_channel, .out_sop, .out_eop, .out_empty,
        .out_error, .chan_error, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .irq);
    // Channelless sink and channelless source variants share the stimulus
    scad_adapter #(.OUT_CHAN_W(0)) scad_adapter_nc_i (.ref_clk, .reset_n, .in_valid, .in_ready(), .in_data,
        .in_channel, .in_sop, .in_eop, .in_empty, .in_error, .out_valid(b_valid), .out_ready, .out_data(),
        .out_channel(b_chan), .out_sop(), .out_eop(), .out_empty(), .out_error(), .chan_error(b_error),
        .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata(), .irq());
    scad_adapter #(.IN_CHAN_W(0)) scad_adapter_ns_i (.ref_clk, .reset_n, .in_valid, .in_ready(), .in_data,
        .in_channel(1'b1), .in_sop, .in_eop, .in_empty, .in_error, .out_valid(c_valid), .out_ready, .out_data(),
        .out_channel(c_chan), .out_sop(), .out_eop(), .out_empty(), .out_error(), .chan_error(c_error),
        .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata(), .irq());
    scad_sink_model scad_sink_model_i (.ref_clk, .reset_n, .slow, .out_valid, .out_ready, .beats);

    always #10 ref_clk = ~ref_clk;

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp)
        begin
            fail_count++;
            $display("mismatch at %0t: saw %h, expected %h", $time, seen, exp);
        end
    endtask

    task automatic end_sim();
        $display("checks %0d, mismatches %0d", checks, fail_count);
        if (fail_count == 0 && checks > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask

    task automatic reg_write(input logic [7:0] a, input logic [31:0] d);
        @(posedge ref_clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge ref_clk);
        reg_wr <= 1'b0;
    endtask

    // Read data is only valid in the cycle after the strobe
    task automatic reg_read(input logic [7:0] a, input logic [31:0] exp);
        @(posedge ref_clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge ref_clk);
        reg_rd <= 1'b0;
        #1;
        check(reg_rdata, exp);
    endtask

    task automatic send(input int ch);
        scad_exp_s e;
        logic [31:0] d;
        logic [4:0] f;
        d = $urandom;
        f = 5'($urandom);
        e = '{ch <= cur_max, ch > cur_max, ch != 0, ch[1:0], f, d};
        @(posedge ref_clk);
        in_valid <= 1'b1;
        in_channel <= ch[3:0];
        in_data <= d;
        {in_sop, in_eop, in_empty, in_error} <= f;
        q.push_back(e);
    endtask

    task automatic idle_wait(input int n);
        @(posedge ref_clk);
        in_valid <= 1'b0;
        repeat (n) @(posedge ref_clk);
        #1;
    endtask

    // Outputs are combinational, settled by the falling edge
    always @(negedge ref_clk)
    begin
        if (in_valid === 1'b1 && q.size() > 0)
        begin
            m = q.pop_front();
            check(out_valid, m.v);
            check(chan_error, m.e);
            check(out_channel, m.ch);
            check(out_data, m.d);
            check({out_sop, out_eop, out_empty, out_error}, m.f);
            check(in_ready, out_ready);
            check(b_error, m.be);
            check({b_valid, b_chan}, 2'b10);
            check({c_valid, c_error, c_chan}, 4'b1000);
            if (m.v && out_ready)
                exp_beats++;
        end
    end

    initial
    begin
        #1000000;
        check(1'b0, 1'b1);
        end_sim();
    end

    initial
    begin
        void'($urandom(32'h2BA6212F));
        repeat (6) @(posedge ref_clk);
        reset_n <= 1'b1;
        reg_read(`SCAD_OFF_STATUS, 32'h0);
        reg_read(`SCAD_OFF_ENABLE, 32'h0);
        reg_read(`SCAD_OFF_SINK_MAX, 32'h2);
        reg_read(`SCAD_OFF_DROPS, 32'h0);
        reg_read(8'h1C, 32'h0);
        reg_read(`SCAD_OFF_INFO, {8'h00, 8'h0F, 4'h4, 4'h2, 8'h01});
        check(irq, 1'b0);
        $display("test reset done");
        slow <= 1'b1;
        for (int c = 0; c < 16; c++)
            send(c);
        idle_wait(2);
        check(irq, 1'b0);
        reg_write(`SCAD_OFF_STATUS, 32'h3);
        reg_read(`SCAD_OFF_STATUS, 32'h2);
        reg_read(`SCAD_OFF_DROPS, 32'd13);
        $display("test channel sweep done");
        reg_write(`SCAD_OFF_ENABLE, 32'h1);
        idle_wait(2);
        check(irq, 1'b0);
        reg_write(`SCAD_OFF_ENABLE, 32'h3);
        idle_wait(2);
        check(irq, 1'b1);
        reg_read(`SCAD_OFF_ENABLE, 32'h3);
        reg_write(`SCAD_OFF_CLEAR, 32'h2);
        idle_wait(2);
        check(irq, 1'b0);
        reg_read(`SCAD_OFF_STATUS, 32'h0);
        $display("test interrupt done");
        reg_write(`SCAD_OFF_SINK_MAX, 32'hF);
        reg_read(`SCAD_OFF_SINK_MAX, 32'hF);
        cur_max = 15;
        for (int c = 15; c >= 0; c--)
            send(c);
        // Drop valid so no unlisted beat reaches the sink during the write
        idle_wait(0);
        reg_write(`SCAD_OFF_SINK_MAX, 32'h0);
        cur_max = 0;
        send(0);
        send(1);
        idle_wait(2);
        reg_read(`SCAD_OFF_DROPS, 32'd14);
        check(beats, exp_beats);
        $display("test sink maximum done");
        end_sim();
    end
endmodule // scad_adapter_tb
